/* hdl/fat_trigger_config.sv */
// fault reaction selectors and input trigger gating registers
//
// Behaviour
// - severe fault reaction selector sits in bits 7:6 of first selection register
// - misc rail group reaction selector sits in bits 5:4 of first register
// - processor rail group reaction selector sits in bits 3:2 of first register
// - controller rail group reaction selector sits in bits 1:0 of first register
// - moderate fault selector in bits 1:0 of second register, bits 7:2 reserved
// - selector codes: 0 immediate off, 1 orderly off, 2 controller error, 3 processor
// - all selectors and gate bits load from nonvolatile defaults in the first cycle after reset is released
// - per input gate bit: 0 passes the pin trigger, 1 blocks it
// - a blocked input presents its block value bit instead of the pin level
// - inputs 1-4 gate bits at 0,2,4,6, block value at next odd bit
// - inputs 5-8 gate bits at 0,2,4,6 in second gate register, likewise
// - two-bit rail group assignment picks which group reaction a rail fault uses
`timescale 1ns/1ps
module fat_trigger_config
  import fat_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire fat_pkg::fat_regs_type nvm_defaults,
  input wire fat_pkg::fat_access_type access,
  output logic [7:0] read_data,
  output logic read_valid,
  input wire logic [fat_pkg::NUM_INPUTS-1:0] input_pin,
  output logic [fat_pkg::NUM_INPUTS-1:0] input_trigger,
  input wire logic [7:0] rail_group_assign,
  input wire fat_pkg::fat_fault_type fault,
  output fat_pkg::fat_request_type reaction_request,
  output logic [3:0] reaction_active
);
  import fat_pkg::*;

  fat_state_type state;
  fat_state_type next_state;
  fat_reaction_type chosen;
  logic any_fault;
  logic [15:0] gate_pairs;
  logic [NUM_INPUTS-1:0] block_bit;
  logic [NUM_INPUTS-1:0] block_value;
  logic [NUM_RAILS-1:0] rail_hit [NUM_GROUPS];

  assign gate_pairs = {state.regs.input_trigger_gate_mid, state.regs.input_trigger_gate_low};

  // one gate pair per input: even bit blocks, odd bit is the forced value
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INPUTS; gi++)
    begin : g_gate
      assign block_bit[gi] = gate_pairs[2*gi];
      assign block_value[gi] = gate_pairs[2*gi+1];
      gate_each_a: assert property (@(posedge core_clk) disable iff (reset)
        input_trigger[gi] == $past(block_bit[gi] ? block_value[gi] : state.pin_sync[gi]))
        else $error("gated input trigger does not follow pin or block value");
    end
  endgenerate

  // per rail group, which rails are assigned to it
  genvar ri;
  generate
    for (ri = 0; ri < NUM_RAILS; ri++)
    begin : g_rail
      assign rail_hit[0][ri] = fault.rail_fault[ri] &&
        (rail_group_assign[2*ri+1 -: 2] == 2'(GROUP_CONTROLLER));
      assign rail_hit[1][ri] = fault.rail_fault[ri] &&
        (rail_group_assign[2*ri+1 -: 2] == 2'(GROUP_PROCESSOR));
      assign rail_hit[2][ri] = fault.rail_fault[ri] &&
        (rail_group_assign[2*ri+1 -: 2] == 2'(GROUP_MISC));
    end
  endgenerate

  // severity order when several faults coincide: severe, moderate, then groups
  always_comb
  begin
    logic [7:0] sel;
    sel = state.regs.severe_and_group_fault_action;
    chosen = REACT_IMMEDIATE_OFF;
    any_fault = 1'b1;
    if (fault.severe)
      chosen = fat_reaction_type'(sel[SEVERE_POS+1 -: 2]);
    else if (fault.moderate)
      chosen = fat_reaction_type'(state.regs.moderate_fault_action[MODERATE_POS+1 -: 2]);
    else if (|rail_hit[2])
      chosen = fat_reaction_type'(sel[MISC_POS+1 -: 2]);
    else if (|rail_hit[1])
      chosen = fat_reaction_type'(sel[PROC_POS+1 -: 2]);
    else if (|rail_hit[0])
      chosen = fat_reaction_type'(sel[CTRL_POS+1 -: 2]);
    else
      any_fault = 1'b0;
  end

  always_comb
  begin
    next_state = state;
    next_state.rvalid = 1'b0;
    next_state.pin_meta = input_pin;
    next_state.pin_sync = state.pin_meta;
    // gating uses the synchronised pin; meta stage is read only by the sync stage
    next_state.trig = (state.pin_sync & ~block_bit) | (block_value & block_bit);
    next_state.request.valid = 1'b0;
    next_state.request.action = REACT_IMMEDIATE_OFF;
    case (state.phase)
      ST_LOAD:
      begin
        // defaults copied once after reset so the port is never an async reset value
        next_state.regs = nvm_defaults;
        next_state.regs.moderate_fault_action = nvm_defaults.moderate_fault_action &
          MODERATE_USED;
        next_state.regs.input_trigger_gate_high = nvm_defaults.input_trigger_gate_high &
          GATE_HIGH_USED;
        next_state.phase = ST_RUN;
      end
      ST_RUN:
      begin
        // selectors sampled in the detection cycle; a write here affects later faults
        if (any_fault)
        begin
          next_state.request.valid = 1'b1;
          next_state.request.action = chosen;
        end
        if (access.wr_en)
        begin
          case (access.addr)
            ADDR_SEVERE_GROUP: next_state.regs.severe_and_group_fault_action = access.wdata;
            ADDR_MODERATE: next_state.regs.moderate_fault_action = access.wdata & MODERATE_USED;
            ADDR_GATE_LOW: next_state.regs.input_trigger_gate_low = access.wdata;
            ADDR_GATE_MID: next_state.regs.input_trigger_gate_mid = access.wdata;
            ADDR_GATE_HIGH:
              next_state.regs.input_trigger_gate_high = access.wdata & GATE_HIGH_USED;
            default: ;
          endcase
        end
        if (access.rd_en)
        begin
          next_state.rvalid = 1'b1;
          case (access.addr)
            ADDR_SEVERE_GROUP: next_state.rdata = state.regs.severe_and_group_fault_action;
            ADDR_MODERATE: next_state.rdata = state.regs.moderate_fault_action;
            ADDR_GATE_LOW: next_state.rdata = state.regs.input_trigger_gate_low;
            ADDR_GATE_MID: next_state.rdata = state.regs.input_trigger_gate_mid;
            ADDR_GATE_HIGH: next_state.rdata = state.regs.input_trigger_gate_high;
            default: next_state.rdata = 8'h00;
          endcase
        end
      end
      default: next_state.phase = ST_LOAD;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state.phase <= ST_LOAD;
      state.regs <= '{RESET_VALUE, RESET_VALUE, RESET_VALUE, RESET_VALUE, RESET_VALUE};
      state.rdata <= 8'h00;
      state.rvalid <= 1'b0;
      state.pin_meta <= 8'h00;
      state.pin_sync <= 8'h00;
      state.trig <= 8'h00;
      state.request <= '{1'b0, REACT_IMMEDIATE_OFF};
    end
    else
      state <= next_state;
  end

  assign read_data = state.rdata;
  assign read_valid = state.rvalid;
  assign input_trigger = state.trig;
  assign reaction_request = state.request;
  assign reaction_active = state.request.valid ? (4'h1 << state.request.action) : 4'h0;

  severe_select_a: assert property (@(posedge core_clk) disable iff (reset)
    (state.phase == ST_RUN && fault.severe) |=> reaction_request.valid &&
      reaction_request.action == $past(state.regs.severe_and_group_fault_action[7:6]))
    else $error("severe fault reaction does not follow bits 7:6");

  moderate_select_a: assert property (@(posedge core_clk) disable iff (reset)
    (state.phase == ST_RUN && !fault.severe && fault.moderate) |=>
      reaction_request.action == $past(state.regs.moderate_fault_action[1:0]))
    else $error("moderate fault reaction does not follow bits 1:0");

  moderate_reserved_a: assert property (@(posedge core_clk) disable iff (reset)
    state.regs.moderate_fault_action[7:2] == 6'h00)
    else $error("reserved moderate bits not zero");

  gate_pass_a: assert property (@(posedge core_clk) disable iff (reset)
    (!block_bit[0] && state.pin_sync[0]) |=>
      input_trigger[0] || block_bit[0] != $past(block_bit[0]))
    else $error("unblocked input 1 not passed");

  gate_force_a: assert property (@(posedge core_clk) disable iff (reset)
    (state.regs.input_trigger_gate_mid[6] && $stable(state.regs.input_trigger_gate_mid)) |=>
      input_trigger[7] == $past(state.regs.input_trigger_gate_mid[7]))
    else $error("blocked input 8 not forced to its block value");

  nvm_load_a: assert property (@(posedge core_clk)
    ($past(reset) && !reset) |=>
      state.regs.input_trigger_gate_low == $past(nvm_defaults.input_trigger_gate_low))
    else $error("defaults not loaded after reset");

  no_fault_idle_a: assert property (@(posedge core_clk) disable iff (reset)
    !any_fault |=> !reaction_request.valid)
    else $error("reaction without fault");

  onehot_action_a: assert property (@(posedge core_clk) disable iff (reset)
    reaction_request.valid |-> $onehot(reaction_active))
    else $error("reaction decode not one-hot");

  misc_select_a: assert property (@(posedge core_clk) disable iff (reset)
    (state.phase == ST_RUN && !fault.severe && !fault.moderate && (|rail_hit[2])) |=>
      reaction_request.valid &&
      reaction_request.action == $past(state.regs.severe_and_group_fault_action[5:4]))
    else $error("misc group fault reaction does not follow bits 5:4");

  proc_select_a: assert property (@(posedge core_clk) disable iff (reset)
    (state.phase == ST_RUN && !fault.severe && !fault.moderate && !(|rail_hit[2]) &&
      (|rail_hit[1])) |=> reaction_request.valid &&
      reaction_request.action == $past(state.regs.severe_and_group_fault_action[3:2]))
    else $error("processor group fault reaction does not follow bits 3:2");

  ctrl_select_a: assert property (@(posedge core_clk) disable iff (reset)
    (state.phase == ST_RUN && !fault.severe && !fault.moderate && !(|rail_hit[2]) &&
      !(|rail_hit[1]) && (|rail_hit[0])) |=> reaction_request.valid &&
      reaction_request.action == $past(state.regs.severe_and_group_fault_action[1:0]))
    else $error("controller group fault reaction does not follow bits 1:0");

  group_none_a: assert property (@(posedge core_clk) disable iff (reset)
    (state.phase == ST_RUN && !fault.severe && !fault.moderate &&
      rail_group_assign == 8'h00) |=> !reaction_request.valid)
    else $error("rail fault without a group raised a reaction");

  severe_write_a: assert property (@(posedge core_clk) disable iff (reset)
    (state.phase == ST_RUN && access.wr_en && access.addr == ADDR_SEVERE_GROUP) |=>
      state.regs.severe_and_group_fault_action == $past(access.wdata))
    else $error("severe and group selector write lost");

  moderate_write_a: assert property (@(posedge core_clk) disable iff (reset)
    (state.phase == ST_RUN && access.wr_en && access.addr == ADDR_MODERATE) |=>
      state.regs.moderate_fault_action == ($past(access.wdata) & MODERATE_USED))
    else $error("moderate selector write lost");

  gate_low_write_a: assert property (@(posedge core_clk) disable iff (reset)
    (state.phase == ST_RUN && access.wr_en && access.addr == ADDR_GATE_LOW) |=>
      state.regs.input_trigger_gate_low == $past(access.wdata))
    else $error("low gate register write lost");

  gate_mid_write_a: assert property (@(posedge core_clk) disable iff (reset)
    (state.phase == ST_RUN && access.wr_en && access.addr == ADDR_GATE_MID) |=>
      state.regs.input_trigger_gate_mid == $past(access.wdata))
    else $error("mid gate register write lost");

  moderate_read_a: assert property (@(posedge core_clk) disable iff (reset)
    (state.phase == ST_RUN && access.rd_en && access.addr == ADDR_MODERATE) |=>
      read_valid && read_data[7:2] == 6'h00 &&
      read_data == $past(state.regs.moderate_fault_action))
    else $error("moderate selector read back wrong");

  severe_read_a: assert property (@(posedge core_clk) disable iff (reset)
    (state.phase == ST_RUN && access.rd_en && access.addr == ADDR_SEVERE_GROUP) |=>
      read_valid && read_data == $past(state.regs.severe_and_group_fault_action))
    else $error("severe and group selector read back wrong");

  gate_low_read_a: assert property (@(posedge core_clk) disable iff (reset)
    (state.phase == ST_RUN && access.rd_en && access.addr == ADDR_GATE_LOW) |=>
      read_valid && read_data == $past(state.regs.input_trigger_gate_low))
    else $error("low gate register read back wrong");

  gate_mid_read_a: assert property (@(posedge core_clk) disable iff (reset)
    (state.phase == ST_RUN && access.rd_en && access.addr == ADDR_GATE_MID) |=>
      read_valid && read_data == $past(state.regs.input_trigger_gate_mid))
    else $error("mid gate register read back wrong");

  sync_chain_a: assert property (@(posedge core_clk) disable iff (reset)
    state.pin_sync == $past(state.pin_meta))
    else $error("pin synchroniser stage skipped");

  load_phase_a: assert property (@(posedge core_clk) disable iff (reset)
    (state.phase == ST_LOAD) |=> (state.phase == ST_RUN))
    else $error("default load phase did not end");

  moderate_load_a: assert property (@(posedge core_clk)
    ($past(reset) && !reset) |=> state.regs.moderate_fault_action ==
      ($past(nvm_defaults.moderate_fault_action) & MODERATE_USED))
    else $error("moderate selector default not loaded");

  severe_load_a: assert property (@(posedge core_clk)
    ($past(reset) && !reset) |=> state.regs.severe_and_group_fault_action ==
      $past(nvm_defaults.severe_and_group_fault_action))
    else $error("severe and group selector default not loaded");

  gate_high_load_a: assert property (@(posedge core_clk)
    ($past(reset) && !reset) |=> state.regs.input_trigger_gate_high ==
      ($past(nvm_defaults.input_trigger_gate_high) & GATE_HIGH_USED))
    else $error("high gate register default not loaded");

  gate_mid_load_a: assert property (@(posedge core_clk)
    ($past(reset) && !reset) |=> state.regs.input_trigger_gate_mid ==
      $past(nvm_defaults.input_trigger_gate_mid))
    else $error("mid gate register default not loaded");

  active_bit_a: assert property (@(posedge core_clk) disable iff (reset)
    reaction_request.valid |-> reaction_active[reaction_request.action])
    else $error("reaction decode bit does not match the action code");

  active_idle_a: assert property (@(posedge core_clk) disable iff (reset)
    !reaction_request.valid |-> reaction_active == 4'h0)
    else $error("reaction decode active without a request");

  write_hold_a: assert property (@(posedge core_clk) disable iff (reset)
    (state.phase == ST_RUN && !access.wr_en) |=> state.regs == $past(state.regs))
    else $error("selectors changed without a write");
endmodule : fat_trigger_config

/* inc/fat_pkg.sv */
// package for the fault action and input trigger configuration block
package fat_pkg;
  localparam logic [7:0] ADDR_SEVERE_GROUP = 8'h44;
  localparam logic [7:0] ADDR_MODERATE = 8'h45;
  localparam logic [7:0] ADDR_GATE_LOW = 8'h46;
  localparam logic [7:0] ADDR_GATE_MID = 8'h47;
  localparam logic [7:0] ADDR_GATE_HIGH = 8'h48;
  localparam logic [7:0] RESET_VALUE = 8'h00;
  localparam int SEVERE_POS = 6;
  localparam int MISC_POS = 4;
  localparam int PROC_POS = 2;
  localparam int CTRL_POS = 0;
  localparam int MODERATE_POS = 0;
  localparam logic [7:0] MODERATE_USED = 8'h03;
  localparam logic [7:0] GATE_HIGH_USED = 8'h0F;
  localparam int NUM_INPUTS = 8;
  localparam int NUM_RAILS = 4;
  localparam int NUM_GROUPS = 3;
  localparam int NVM_LOAD_CYCLES = 1;

  typedef enum logic [1:0] {
    REACT_IMMEDIATE_OFF,
    REACT_ORDERLY_OFF,
    REACT_CTRL_POWER_ERR,
    REACT_PROC_POWER_ERR
  } fat_reaction_type;

  typedef enum logic [1:0] {
    GROUP_NONE,
    GROUP_CONTROLLER,
    GROUP_PROCESSOR,
    GROUP_MISC
  } fat_group_type;

  typedef enum logic [1:0] {
    ST_LOAD,
    ST_RUN
  } fat_phase_type;

  typedef struct packed {
    logic [7:0] severe_and_group_fault_action;
    logic [7:0] moderate_fault_action;
    logic [7:0] input_trigger_gate_low;
    logic [7:0] input_trigger_gate_mid;
    logic [7:0] input_trigger_gate_high;
  } fat_regs_type;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } fat_access_type;

  typedef struct packed {
    logic severe;
    logic moderate;
    logic [NUM_RAILS-1:0] rail_fault;
  } fat_fault_type;

  typedef struct packed {
    logic valid;
    fat_reaction_type action;
  } fat_request_type;

  typedef struct packed {
    fat_phase_type phase;
    fat_regs_type regs;
    logic [7:0] rdata;
    logic rvalid;
    logic [NUM_INPUTS-1:0] pin_meta;
    logic [NUM_INPUTS-1:0] pin_sync;
    logic [NUM_INPUTS-1:0] trig;
    fat_request_type request;
  } fat_state_type;
endpackage : fat_pkg

/* verification/tb_top.sv */
// self-checking bench for the fault action and input trigger configuration block
`timescale 1ns/1ps
module tb_top;
  import fat_pkg::*;
  logic core_clk;
  logic reset;
  fat_regs_type nvm_defaults;
  fat_access_type access;
  logic [7:0] read_data;
  logic read_valid;
  logic [7:0] input_pin;
  logic [7:0] input_trigger;
  logic [7:0] rail_group_assign;
  fat_fault_type fault;
  fat_request_type reaction_request;
  logic [3:0] reaction_active;
  int err_count;
  int check_count;
  logic [31:0] rng;
  logic [7:0] shadow [5];
  logic [7:0] used [5];
  logic [7:0] e;
  logic [1:0] c;

  fat_trigger_config u_dut (
    .core_clk(core_clk),
    .reset(reset),
    .nvm_defaults(nvm_defaults),
    .access(access),
    .read_data(read_data),
    .read_valid(read_valid),
    .input_pin(input_pin),
    .input_trigger(input_trigger),
    .rail_group_assign(rail_group_assign),
    .fault(fault),
    .reaction_request(reaction_request),
    .reaction_active(reaction_active)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  function automatic logic [7:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction : rnd

  // a blocked input shows its block value, otherwise the pin level
  function automatic logic [7:0] gated(logic [7:0] pin, logic [7:0] lo, logic [7:0] mid);
    logic [7:0] r;
    logic [7:0] g;
    for (int k = 0; k < 8; k++)
    begin
      g = (k < 4) ? lo : mid;
      r[k] = g[2 * (k % 4)] ? g[2 * (k % 4) + 1] : pin[k];
    end
    return r;
  endfunction : gated

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic reg_write(logic [7:0] addr, logic [7:0] data);
    // one idle edge between transfers so no strobe is set twice in a time step
    @(negedge core_clk);
    access = '{wr_en: 1'b1, rd_en: 1'b0, addr: addr, wdata: data};
    @(negedge core_clk);
    access.wr_en = 1'b0;
    if (addr >= ADDR_SEVERE_GROUP && addr <= ADDR_GATE_HIGH)
      shadow[addr - 8'h44] = data & used[addr - 8'h44];
  endtask : reg_write

  task automatic reg_read(logic [7:0] addr, logic [7:0] exp);
    @(negedge core_clk);
    access = '{wr_en: 1'b0, rd_en: 1'b1, addr: addr, wdata: 8'h00};
    @(negedge core_clk);
    access.rd_en = 1'b0;
    check("read_valid", {7'h00, read_valid}, 8'h01);
    check("read_data", read_data, exp);
  endtask : reg_read

  // fault seen in one cycle must yield the selected reaction in the next
  task automatic fire(logic [5:0] f, logic [1:0] code);
    @(negedge core_clk);
    fault = f;
    @(negedge core_clk);
    fault = '0;
    check("reaction_request", {5'h00, reaction_request}, {6'h01, code});
    check("reaction_active", {4'h0, reaction_active}, 8'h01 << code);
  endtask : fire

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish

  initial
  begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    tally_and_finish();
  end

  initial
  begin
    err_count = 0;
    check_count = 0;
    rng = 32'd67945;
    used = '{8'hFF, MODERATE_USED, 8'hFF, 8'hFF, GATE_HIGH_USED};
    reset = 1'b1;
    access = '0;
    input_pin = 8'h00;
    rail_group_assign = 8'hF9;
    fault = '0;
    nvm_defaults = {rnd(), rnd(), rnd(), rnd(), rnd()};
    repeat (6) @(negedge core_clk);
    reset = 1'b0;
    repeat (2) @(negedge core_clk);
    // reserved bits of the defaults must not survive the load
    for (int i = 0; i < 5; i++)
      reg_read(8'h44 + i[7:0], nvm_defaults[8 * (4 - i) +: 8] & used[i]);
    $display("test nvm defaults done");
    for (int i = 0; i < 5; i++)
      shadow[i] = nvm_defaults[8 * (4 - i) +: 8] & used[i];
    repeat (4)
    begin
      for (int a = 8'h44; a <= 8'h49; a++)
        reg_write(a[7:0], rnd());
      for (int a = 0; a < 5; a++)
        reg_read(8'h44 + a[7:0], shadow[a]);
      reg_read(8'h49, 8'h00);
    end
    $display("test register access done");
    // rails 0,1,2 sit in controller, processor and misc groups
    for (int k = 0; k < 4; k++)
    begin
      c = k[1:0];
      reg_write(ADDR_SEVERE_GROUP, {c, c + 2'd1, c + 2'd2, c + 2'd3});
      reg_write(ADDR_MODERATE, {6'h3F, c + 2'd2});
      fire(6'b110111, c);
      fire(6'b010111, c + 2'd2);
      fire(6'b000111, c + 2'd1);
      fire(6'b000011, c + 2'd2);
      fire(6'b000001, c + 2'd3);
    end
    // rail 0 moved to processor, rail 1 to controller, then no group at all
    rail_group_assign = 8'h06;
    fire(6'b000001, 2'd1);
    fire(6'b000011, 2'd1);
    fire(6'b000010, 2'd2);
    rail_group_assign = 8'h00;
    @(negedge core_clk);
    fault = 6'b001111;
    @(negedge core_clk);
    fault = '0;
    check("reaction_request", {5'h00, reaction_request}, 8'h00);
    // a write in the fault cycle must not change that fault's reaction
    @(negedge core_clk);
    access = '{wr_en: 1'b1, rd_en: 1'b0, addr: ADDR_MODERATE, wdata: 8'hFE};
    fault = 6'b010000;
    @(negedge core_clk);
    access.wr_en = 1'b0;
    fault = '0;
    check("reaction_request", {5'h00, reaction_request}, 8'h05);
    check("reaction_active", {4'h0, reaction_active}, 8'h02);
    fire(6'b010000, 2'd2);
    $display("test fault reactions done");
    repeat (24)
    begin
      reg_write(ADDR_GATE_LOW, rnd());
      reg_write(ADDR_GATE_MID, rnd());
      input_pin = rnd();
      repeat (4) @(negedge core_clk);
      e = gated(input_pin, shadow[2], shadow[3]);
      check("input_trigger", input_trigger, e);
    end
    $display("test input gating done");
    tally_and_finish();
  end
endmodule : tb_top
